// >>> design/motor_loop_pkg.sv
// Shared constants, types and saturation helper for the motion loops
package motor_loop_pkg;
  // --------------------------------------------------------------------
  // Number formats
  // --------------------------------------------------------------------
  localparam int DW    = 16;  // Signed data and gain width
  localparam int ACC_W = 40;  // Internal accumulation width
  localparam int FRAC  = 8;   // Fraction bits of gains and currents
  localparam int CNT_W = 16;
  // --------------------------------------------------------------------
  // Loop rates
  // --------------------------------------------------------------------
  localparam int CLK_HZ      = 50_000_000;
  localparam int POS_LOOP_HZ = 1_000;
  localparam int VEL_LOOP_HZ = 5_000;
  localparam int FAST_LOOP_HZ = 40_000;
  localparam int FAST_DIV    = CLK_HZ / FAST_LOOP_HZ;
  localparam int NUM_RATES   = 3;
  localparam int RATE_FAST   = 0;
  localparam int RATE_VEL    = 1;
  localparam int RATE_POS    = 2;
  // --------------------------------------------------------------------
  // Power-up defaults
  // --------------------------------------------------------------------
  localparam int CUR_LIMIT_AMPS = 10;
  localparam logic signed [DW-1:0] DEF_CUR_LIMIT =
    DW'(CUR_LIMIT_AMPS << FRAC);
  localparam logic [DW-1:0] DEF_BW_HZ    = 16'h00C8;
  localparam logic signed [DW-1:0] DEF_VEL_KP = 16'h0040;
  localparam logic signed [DW-1:0] DEF_VEL_KI = 16'h0010;
  localparam logic signed [DW-1:0] DEF_VEL_KD = 16'h0000;
  localparam logic signed [DW-1:0] DEF_VEL_WU = 16'h0100;
  localparam logic signed [DW-1:0] DEF_POS_KP = 16'h0200;
  localparam logic signed [DW-1:0] DEF_POS_KI = 16'h0000;
  localparam logic signed [DW-1:0] DEF_POS_KD = 16'h0000;
  localparam logic signed [DW-1:0] DEF_POS_WU = 16'h0100;
  localparam logic signed [DW-1:0] DEF_IMP_KP = 16'h0100;
  localparam logic signed [DW-1:0] DEF_IMP_KD = 16'h0010;
  // Current PI gains per hertz of torque bandwidth (Q8.8 per Hz)
  localparam logic signed [DW-1:0] CUR_KP_PER_HZ = 16'h0002;
  localparam logic signed [DW-1:0] CUR_KI_PER_HZ = 16'h0001;
  localparam logic signed [DW-1:0] VOLT_LIMIT    = 16'h7000;
  // Torque to current scale, Q8.8
  localparam logic signed [DW-1:0] AMP_PER_NM    = 16'h0100;
  localparam logic signed [DW-1:0] ZERO          = 16'h0000;
  localparam logic [CNT_W-1:0] NV_WAIT_CYCLES    = 16'h0040;
  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IDLE = 2'h0,
    MODE_VEL  = 2'h1,
    MODE_POS  = 2'h2,
    MODE_IMP  = 2'h3
  } mode_t;
  typedef enum logic [1:0] {
    BOOT_REQ  = 2'h0,
    BOOT_WAIT = 2'h1,
    BOOT_RUN  = 2'h3
  } boot_t;

  // Symmetric clamp to -lim..+lim, negative limit acts as zero
  function automatic logic signed [DW-1:0] sat_fn(
    input logic signed [ACC_W-1:0] x,
    input logic signed [DW-1:0]    lim);
    logic signed [ACC_W-1:0] l;
    l = (lim < ZERO) ? '0 : ACC_W'(lim);
    if (x > l)
      return DW'(l);
    else if (x < -l)
      return DW'(-l);
    else
      return DW'(x);
  endfunction : sat_fn
endpackage : motor_loop_pkg

// >>> design/pid_unit.sv
// PID stage with clamped integral and saturated output
module pid_unit import motor_loop_pkg::*; (
  // Clock and control
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 tick_in,
  input  wire logic                 clear_in,
  // Operands
  input  wire logic signed [DW-1:0] target_in,
  input  wire logic signed [DW-1:0] meas_in,
  input  wire logic signed [DW-1:0] kp_in,
  input  wire logic signed [DW-1:0] ki_in,
  input  wire logic signed [DW-1:0] kd_in,
  input  wire logic signed [DW-1:0] windup_in,
  input  wire logic signed [DW-1:0] limit_in,
  // Result
  output logic signed [DW-1:0]      out_out
);
  logic signed [ACC_W-1:0] err;
  logic signed [ACC_W-1:0] prev_err_r;
  logic signed [ACC_W-1:0] prev_err_nxt;
  logic signed [DW-1:0]    integ_r;
  logic signed [DW-1:0]    integ_nxt;
  logic signed [DW-1:0]    out_nxt;
  logic signed [ACC_W-1:0] p_term;
  logic signed [ACC_W-1:0] d_term;

  always_comb begin
    err          = ACC_W'(target_in) - ACC_W'(meas_in);
    p_term       = (err * ACC_W'(kp_in)) >>> FRAC;
    d_term       = ((err - prev_err_r) * ACC_W'(kd_in)) >>> FRAC;
    integ_nxt    = integ_r;
    prev_err_nxt = prev_err_r;
    out_nxt      = out_out;
    if (clear_in) begin
      integ_nxt    = ZERO;
      prev_err_nxt = '0;
      out_nxt      = ZERO;
    end else if (tick_in) begin
      // Bound the running integral by the windup value
      integ_nxt    = sat_fn(ACC_W'(integ_r)
                     + ((err * ACC_W'(ki_in)) >>> FRAC), windup_in);
      prev_err_nxt = err;
      out_nxt      = sat_fn(p_term + ACC_W'(integ_nxt) + d_term,
                            limit_in);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      integ_r    <= ZERO;
      prev_err_r <= '0;
      out_out    <= ZERO;
    end else begin
      integ_r    <= integ_nxt;
      prev_err_r <= prev_err_nxt;
      out_out    <= out_nxt;
    end
  end
endmodule : pid_unit

// >>> design/motor_loop_limits.sv
// Motion loops, current loop and limit chain of the actuator drive
//
// Function
// - Power-up reloads default gains in all controllers
// - Velocity PID with kP, kI, kD, windup
// - Integral term clamped to windup value
// - Position PID feeds velocity PID target
// - Position PID output clamped to speed ceiling
// - Impedance: kP on position, kD on velocity
// - Current PI gains derived from bandwidth
// - Phase-current limit is the last clamp
// - Phase-current limit defaults to ten amperes
// - Current limit saved, restored at power-up
// - Torque, speed limits act before current limit
// - Speed ceiling only in position mode
// - Torque limit in every motion mode
// - Impedance adds host feedforward torque
// - Velocity error from target and estimate
module motor_loop_limits import motor_loop_pkg::*; #(
  parameter int POS_DIV = CLK_HZ / POS_LOOP_HZ,
  parameter int VEL_DIV = CLK_HZ / VEL_LOOP_HZ
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_n_in,
  // Mode and targets
  input  wire logic [1:0]           mode_in,
  input  wire logic signed [DW-1:0] pos_target_in,
  input  wire logic signed [DW-1:0] vel_target_in,
  input  wire logic signed [DW-1:0] feedforward_command_in,
  // Gain loading
  input  wire logic                 vel_gain_load_in,
  input  wire logic                 pos_gain_load_in,
  input  wire logic                 imp_gain_load_in,
  input  wire logic signed [DW-1:0] gain_kp_in,
  input  wire logic signed [DW-1:0] gain_ki_in,
  input  wire logic signed [DW-1:0] gain_kd_in,
  input  wire logic signed [DW-1:0] gain_windup_in,
  input  wire logic                 bw_load_in,
  input  wire logic [DW-1:0]        bw_hz_in,
  // Limits
  input  wire logic signed [DW-1:0] max_torque_in,
  input  wire logic signed [DW-1:0] outer_loop_speed_ceiling_in,
  input  wire logic                 cur_limit_load_in,
  input  wire logic signed [DW-1:0] cur_limit_in,
  // Measurements
  input  wire logic signed [DW-1:0] pos_meas_in,
  input  wire logic signed [DW-1:0] vel_meas_in,
  input  wire logic signed [DW-1:0] cur_meas_in,
  // Non-volatile store
  input  wire logic                 nv_save_in,
  output logic                      nv_write_out,
  output logic signed [DW-1:0]      nv_wdata_out,
  output logic                      nv_read_out,
  input  wire logic                 nv_rvalid_in,
  input  wire logic signed [DW-1:0] nv_rdata_in,
  // Commands and status
  output logic signed [DW-1:0]      vel_setpoint_out,
  output logic signed [DW-1:0]      torque_cmd_out,
  output logic signed [DW-1:0]      current_cmd_out,
  output logic signed [DW-1:0]      voltage_cmd_out,
  output logic signed [DW-1:0]      cur_limit_out,
  output logic                      restore_done_out
);
  // --------------------------------------------------------------------
  // Loop rate dividers
  // --------------------------------------------------------------------
  localparam int DIV_VAL [NUM_RATES] = '{FAST_DIV, VEL_DIV, POS_DIV};
  logic [NUM_RATES-1:0] tick;

  genvar g;
  generate
    for (g = 0; g < NUM_RATES; g++) begin : g_div
      logic [CNT_W-1:0] cnt_r;
      logic [CNT_W-1:0] cnt_nxt;
      assign tick[g] = (cnt_r == CNT_W'(DIV_VAL[g] - 1));
      always_comb begin
        cnt_nxt = tick[g] ? '0 : cnt_r + 1'b1;
      end
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          cnt_r <= '0;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Gain sets, bandwidth and current limit
  // --------------------------------------------------------------------
  logic signed [DW-1:0] vel_kp_r, vel_ki_r, vel_kd_r, vel_wu_r;
  logic signed [DW-1:0] pos_kp_r, pos_ki_r, pos_kd_r, pos_wu_r;
  logic signed [DW-1:0] imp_kp_r, imp_kd_r;
  logic signed [DW-1:0] vel_kp_nxt, vel_ki_nxt, vel_kd_nxt, vel_wu_nxt;
  logic signed [DW-1:0] pos_kp_nxt, pos_ki_nxt, pos_kd_nxt, pos_wu_nxt;
  logic signed [DW-1:0] imp_kp_nxt, imp_kd_nxt;
  logic [DW-1:0]        bw_r, bw_nxt;
  logic signed [DW-1:0] cur_lim_r, cur_lim_nxt;
  boot_t                boot_r, boot_nxt;
  logic [CNT_W-1:0]     wait_r, wait_nxt;
  logic                 nv_wr_nxt;
  logic signed [DW-1:0] nv_wdata_nxt;

  always_comb begin
    {vel_kp_nxt, vel_ki_nxt, vel_kd_nxt, vel_wu_nxt} =
      {vel_kp_r, vel_ki_r, vel_kd_r, vel_wu_r};
    {pos_kp_nxt, pos_ki_nxt, pos_kd_nxt, pos_wu_nxt} =
      {pos_kp_r, pos_ki_r, pos_kd_r, pos_wu_r};
    {imp_kp_nxt, imp_kd_nxt} = {imp_kp_r, imp_kd_r};
    bw_nxt       = bw_r;
    cur_lim_nxt  = cur_lim_r;
    boot_nxt     = boot_r;
    wait_nxt     = wait_r;
    nv_wr_nxt    = 1'b0;
    nv_wdata_nxt = nv_wdata_out;
    if (vel_gain_load_in) begin
      {vel_kp_nxt, vel_ki_nxt, vel_kd_nxt, vel_wu_nxt} =
        {gain_kp_in, gain_ki_in, gain_kd_in, gain_windup_in};
    end
    if (pos_gain_load_in) begin
      {pos_kp_nxt, pos_ki_nxt, pos_kd_nxt, pos_wu_nxt} =
        {gain_kp_in, gain_ki_in, gain_kd_in, gain_windup_in};
    end
    // No integral gain is taken for impedance
    if (imp_gain_load_in) begin
      {imp_kp_nxt, imp_kd_nxt} = {gain_kp_in, gain_kd_in};
    end
    if (bw_load_in) begin
      bw_nxt = bw_hz_in;
    end
    if (cur_limit_load_in) begin
      cur_lim_nxt = cur_limit_in;
    end
    if (nv_save_in) begin
      nv_wr_nxt    = 1'b1;
      nv_wdata_nxt = cur_lim_nxt;
    end
    // Stored limit is fetched once after reset; a silent store
    // keeps the built-in default instead of hanging the drive
    unique case (boot_r)
      BOOT_REQ: begin
        boot_nxt = BOOT_WAIT;
        wait_nxt = '0;
      end
      BOOT_WAIT: begin
        wait_nxt = wait_r + 1'b1;
        if (nv_rvalid_in) begin
          cur_lim_nxt = nv_rdata_in;
          boot_nxt    = BOOT_RUN;
        end else if (wait_r == NV_WAIT_CYCLES) begin
          boot_nxt = BOOT_RUN;
        end
      end
      BOOT_RUN: begin
        boot_nxt = BOOT_RUN;
      end
      default: begin
        boot_nxt = BOOT_REQ;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // Defaults replace any gains from the previous session
      {vel_kp_r, vel_ki_r, vel_kd_r, vel_wu_r} <=
        {DEF_VEL_KP, DEF_VEL_KI, DEF_VEL_KD, DEF_VEL_WU};
      {pos_kp_r, pos_ki_r, pos_kd_r, pos_wu_r} <=
        {DEF_POS_KP, DEF_POS_KI, DEF_POS_KD, DEF_POS_WU};
      {imp_kp_r, imp_kd_r} <= {DEF_IMP_KP, DEF_IMP_KD};
      bw_r         <= DEF_BW_HZ;
      cur_lim_r    <= DEF_CUR_LIMIT;
      boot_r       <= BOOT_REQ;
      wait_r       <= '0;
      nv_write_out <= 1'b0;
      nv_wdata_out <= ZERO;
    end else begin
      {vel_kp_r, vel_ki_r, vel_kd_r, vel_wu_r} <=
        {vel_kp_nxt, vel_ki_nxt, vel_kd_nxt, vel_wu_nxt};
      {pos_kp_r, pos_ki_r, pos_kd_r, pos_wu_r} <=
        {pos_kp_nxt, pos_ki_nxt, pos_kd_nxt, pos_wu_nxt};
      {imp_kp_r, imp_kd_r} <= {imp_kp_nxt, imp_kd_nxt};
      bw_r         <= bw_nxt;
      cur_lim_r    <= cur_lim_nxt;
      boot_r       <= boot_nxt;
      wait_r       <= wait_nxt;
      nv_write_out <= nv_wr_nxt;
      nv_wdata_out <= nv_wdata_nxt;
    end
  end

  assign nv_read_out      = (boot_r == BOOT_WAIT);
  assign restore_done_out = (boot_r == BOOT_RUN);
  assign cur_limit_out    = cur_lim_r;

  // --------------------------------------------------------------------
  // Motion controllers
  // --------------------------------------------------------------------
  mode_t                mode;
  logic                 run;
  logic signed [DW-1:0] pos_out;
  logic signed [DW-1:0] vel_out;
  logic signed [DW-1:0] vel_tgt;
  logic signed [DW-1:0] cur_kp;
  logic signed [DW-1:0] cur_ki;
  logic signed [ACC_W-1:0] imp_sum;
  logic signed [DW-1:0] imp_r, imp_nxt;
  logic signed [DW-1:0] torque_nxt, current_nxt;

  assign mode = mode_t'(mode_in);
  // Loops stay cleared until the stored limit is back or the store wait times out
  assign run  = restore_done_out;

  // Outer loop clamped to speed ceiling, only in position mode
  pid_unit u_pos_pid (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .tick_in   (tick[RATE_POS]),
    .clear_in  (!run || mode != MODE_POS),
    .target_in (pos_target_in),
    .meas_in   (pos_meas_in),
    .kp_in     (pos_kp_r),
    .ki_in     (pos_ki_r),
    .kd_in     (pos_kd_r),
    .windup_in (pos_wu_r),
    .limit_in  (outer_loop_speed_ceiling_in),
    .out_out   (pos_out)
  );

  // Cascade: position result becomes the velocity target
  assign vel_tgt = (mode == MODE_POS) ? pos_out
                                      : vel_target_in;

  // Torque limit applies to the velocity loop result
  pid_unit u_vel_pid (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .tick_in   (tick[RATE_VEL]),
    .clear_in  (!run || !(mode == MODE_VEL || mode == MODE_POS)),
    .target_in (vel_tgt),
    .meas_in   (vel_meas_in),
    .kp_in     (vel_kp_r),
    .ki_in     (vel_ki_r),
    .kd_in     (vel_kd_r),
    .windup_in (vel_wu_r),
    .limit_in  (max_torque_in),
    .out_out   (vel_out)
  );

  always_comb begin
    imp_sum = ((ACC_W'(pos_target_in) - ACC_W'(pos_meas_in))
               * ACC_W'(imp_kp_r) >>> FRAC)
            + ((ACC_W'(vel_target_in) - ACC_W'(vel_meas_in))
               * ACC_W'(imp_kd_r) >>> FRAC)
            + ACC_W'(feedforward_command_in);
    imp_nxt = imp_r;
    if (!run || mode != MODE_IMP) begin
      imp_nxt = ZERO;
    end else if (tick[RATE_FAST]) begin
      imp_nxt = sat_fn(imp_sum, max_torque_in);
    end
    unique case (mode)
      MODE_VEL, MODE_POS: torque_nxt = vel_out;
      MODE_IMP:           torque_nxt = imp_r;
      MODE_IDLE:          torque_nxt = ZERO;
    endcase
    // Current clamp sits after every torque stage
    current_nxt = sat_fn((ACC_W'(torque_nxt) * ACC_W'(AMP_PER_NM))
                         >>> FRAC, cur_lim_r);
    // Current gains follow bandwidth; no direct host path
    cur_kp = sat_fn(ACC_W'(bw_r) * ACC_W'(CUR_KP_PER_HZ), VOLT_LIMIT);
    cur_ki = sat_fn(ACC_W'(bw_r) * ACC_W'(CUR_KI_PER_HZ), VOLT_LIMIT);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      imp_r            <= ZERO;
      torque_cmd_out   <= ZERO;
      current_cmd_out  <= ZERO;
      vel_setpoint_out <= ZERO;
    end else begin
      imp_r            <= imp_nxt;
      torque_cmd_out   <= torque_nxt;
      current_cmd_out  <= current_nxt;
      vel_setpoint_out <= vel_tgt;
    end
  end

  // --------------------------------------------------------------------
  // Current PI
  // --------------------------------------------------------------------
  pid_unit u_cur_pi (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .tick_in   (tick[RATE_FAST]),
    .clear_in  (!run || mode == MODE_IDLE),
    .target_in (current_cmd_out),
    .meas_in   (cur_meas_in),
    .kp_in     (cur_kp),
    .ki_in     (cur_ki),
    .kd_in     (ZERO),
    .windup_in (VOLT_LIMIT),
    .limit_in  (VOLT_LIMIT),
    .out_out   (voltage_cmd_out)
  );
endmodule : motor_loop_limits

// >>> bench/motor_loop_limits_sva.sv
// Concurrent checks on the motion loop ports
module motor_loop_limits_sva import motor_loop_pkg::*; (
  // Clock and reset
  input wire logic                 clk_in,
  input wire logic                 rst_n_in,
  // Inputs
  input wire logic [1:0]           mode_in,
  input wire logic signed [DW-1:0] max_torque_in,
  input wire logic signed [DW-1:0] outer_loop_speed_ceiling_in,
  input wire logic                 cur_limit_load_in,
  input wire logic signed [DW-1:0] cur_limit_in,
  input wire logic                 nv_save_in,
  input wire logic                 nv_rvalid_in,
  input wire logic signed [DW-1:0] nv_rdata_in,
  // Outputs
  input wire logic                 nv_write_out,
  input wire logic signed [DW-1:0] nv_wdata_out,
  input wire logic                 nv_read_out,
  input wire logic signed [DW-1:0] vel_setpoint_out,
  input wire logic signed [DW-1:0] torque_cmd_out,
  input wire logic signed [DW-1:0] current_cmd_out,
  input wire logic signed [DW-1:0] cur_limit_out,
  input wire logic                 restore_done_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  nv_pulse_a: assert property (
    nv_save_in |=> nv_write_out ##1 !nv_write_out)
    else $error("save pulse wrong");
  nv_data_a: assert property (
    nv_save_in && !cur_limit_load_in |=> nv_wdata_out == $past(cur_limit_out))
    else $error("saved limit wrong");
  lim_load_a: assert property (
    cur_limit_load_in && !nv_read_out |=> cur_limit_out == $past(cur_limit_in))
    else $error("limit load wrong");
  nv_restore_a: assert property (
    nv_read_out && nv_rvalid_in && !cur_limit_load_in
    |=> cur_limit_out == $past(nv_rdata_in) && restore_done_out)
    else $error("restored limit wrong");
  boot_wait_a: assert property (
    $rose(nv_read_out) |-> ##[1:70] (restore_done_out && !nv_read_out))
    else $error("restore never ends");
  done_keep_a: assert property (
    restore_done_out |=> restore_done_out)
    else $error("restore done dropped");
  boot_hold_a: assert property (
    !restore_done_out |-> torque_cmd_out == ZERO && current_cmd_out == ZERO)
    else $error("loops active before restore");
  cur_clamp_a: assert property (
    $stable(cur_limit_out) && !cur_limit_out[DW-1]
    && ($changed(current_cmd_out) || $changed(torque_cmd_out))
    |-> current_cmd_out == ((torque_cmd_out > cur_limit_out) ? cur_limit_out :
      (torque_cmd_out < -cur_limit_out) ? -cur_limit_out : torque_cmd_out))
    else $error("current clamp wrong");
  torque_lim_a: assert property (
    $changed(torque_cmd_out) && $stable(mode_in) && $stable(max_torque_in)
    && $past(max_torque_in, 2) == max_torque_in && !max_torque_in[DW-1]
    |-> torque_cmd_out <= max_torque_in && torque_cmd_out >= -max_torque_in)
    else $error("torque limit exceeded");
  ceil_hold_a: assert property (
    mode_in == 2'h2 && $past(mode_in) == 2'h2 && $changed(vel_setpoint_out)
    && $stable(outer_loop_speed_ceiling_in) && !outer_loop_speed_ceiling_in[15]
    |-> vel_setpoint_out <= outer_loop_speed_ceiling_in
    && vel_setpoint_out >= -outer_loop_speed_ceiling_in)
    else $error("speed ceiling exceeded");
endmodule : motor_loop_limits_sva

bind motor_loop_limits motor_loop_limits_sva sva_u (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .mode_in(mode_in),
  .max_torque_in(max_torque_in),
  .outer_loop_speed_ceiling_in(outer_loop_speed_ceiling_in),
  .cur_limit_load_in(cur_limit_load_in), .cur_limit_in(cur_limit_in),
  .nv_save_in(nv_save_in), .nv_rvalid_in(nv_rvalid_in),
  .nv_rdata_in(nv_rdata_in), .nv_write_out(nv_write_out),
  .nv_wdata_out(nv_wdata_out), .nv_read_out(nv_read_out),
  .vel_setpoint_out(vel_setpoint_out), .torque_cmd_out(torque_cmd_out),
  .current_cmd_out(current_cmd_out), .cur_limit_out(cur_limit_out),
  .restore_done_out(restore_done_out));

// >>> bench/nv_store_model.sv
// Non-volatile store partner that keeps the saved limit
module nv_store_model import motor_loop_pkg::*; #(
  parameter int DELAY = 3
) (
  // Clock
  input  wire logic                 clk_in,
  // Store port
  input  wire logic                 answer_in,
  input  wire logic                 read_in,
  input  wire logic                 write_in,
  input  wire logic signed [DW-1:0] wdata_in,
  output logic                      rvalid_out,
  output logic signed [DW-1:0]      rdata_out
);
  logic signed [DW-1:0] mem_r = 16'h0500;
  logic                 v_r   = 1'b0;
  int                   cnt_r = 0;
  // --------------------------------
  // Answer late, never twice a read
  // --------------------------------
  always @(posedge clk_in) begin
    if (write_in)
      mem_r <= wdata_in;
    cnt_r <= read_in ? cnt_r + 1 : 0;
    v_r <= read_in && answer_in && cnt_r == DELAY;
  end
  assign rvalid_out = v_r;
  // Junk on the data lines outside the valid cycle
  assign rdata_out = v_r ? mem_r : ~mem_r;
endmodule : nv_store_model

// >>> bench/motor_loop_limits_tb_top.sv
// Self-checking bench for the motion loops and limit chain
module motor_loop_limits_tb_top import motor_loop_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_in, rst_n, vl, pl, il, bl, cl, sv, ans;
  logic                 nw, nr, nrv, done;
  logic [1:0]           mode;
  logic [DW-1:0]        bw;
  logic signed [DW-1:0] pt, vt, ff, kp, ki, kd, wu, mt, sc, clim;
  logic signed [DW-1:0] pm, vm, cm, nwd, nrd, vsp, tq, cur, volt, lim;
  int                   n_errors = 0;
  int                   n_tests = 0;
  string nm [7] = '{"torque", "voltage", "vel_setpoint", "current",
                    "cur_limit", "restore_done", "nv_wdata"};

  // Short loop periods keep the run brief
  motor_loop_limits #(.POS_DIV(20), .VEL_DIV(10)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n), .mode_in(mode),
    .pos_target_in(pt), .vel_target_in(vt), .feedforward_command_in(ff),
    .vel_gain_load_in(vl), .pos_gain_load_in(pl), .imp_gain_load_in(il),
    .gain_kp_in(kp), .gain_ki_in(ki), .gain_kd_in(kd),
    .gain_windup_in(wu), .bw_load_in(bl), .bw_hz_in(bw),
    .max_torque_in(mt), .outer_loop_speed_ceiling_in(sc),
    .cur_limit_load_in(cl), .cur_limit_in(clim), .pos_meas_in(pm),
    .vel_meas_in(vm), .cur_meas_in(cm), .nv_save_in(sv),
    .nv_write_out(nw), .nv_wdata_out(nwd), .nv_read_out(nr),
    .nv_rvalid_in(nrv), .nv_rdata_in(nrd), .vel_setpoint_out(vsp),
    .torque_cmd_out(tq), .current_cmd_out(cur), .voltage_cmd_out(volt),
    .cur_limit_out(lim), .restore_done_out(done));
  nv_store_model #(.DELAY(3)) nv_u (
    .clk_in(clk_in), .answer_in(ans), .read_in(nr), .write_in(nw),
    .wdata_in(nwd), .rvalid_out(nrv), .rdata_out(nrd));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // --------------------------------
  // Shared tasks
  // --------------------------------
  function automatic logic [DW-1:0] pick(input int k);
    case (k)
      0: return tq;
      1: return volt;
      2: return vsp;
      3: return cur;
      4: return lim;
      5: return {15'h0000, done};
      default: return nwd;
    endcase
  endfunction : pick
  task automatic close_out();
    $display("Checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic chk(input string s, input logic [DW-1:0] got, e);
    n_tests++;
    if (got !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, e, got);
    end
  endtask : chk
  // Waits up to n cycles for the value, then compares
  task automatic weq(input int k, input logic [DW-1:0] e, input int n);
    int i;
    for (i = 0; i < n && pick(k) !== e; i++)
      @(negedge clk_in);
    chk(nm[k], pick(k), e);
    if (n > 0 && pick(k) !== e)
      close_out();
  endtask : weq
  task automatic load(input int s, input logic [DW-1:0] a, b, c, d);
    @(posedge clk_in);
    {kp, ki, kd, wu} <= {a, b, c, d};
    {clim, bw} <= {a, a};
    {vl, pl, il, cl, sv, bl} <= 6'h20 >> s;
    @(posedge clk_in);
    {vl, pl, il, cl, sv, bl} <= 6'h00;
    @(negedge clk_in);
  endtask : load
  task automatic boot(input logic a, input logic [DW-1:0] b);
    @(posedge clk_in);
    ans <= a;
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_in);
    weq(4, DEF_CUR_LIMIT, 0);
    rst_n <= 1'b1;
    load(5, b, 0, 0, 0);
    weq(5, 16'h0001, 100);
  endtask : boot
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_vel();
    load(0, 16'h0000, 16'h0100, 16'h0000, 16'h0030);
    @(posedge clk_in);
    {mode, vt, sc, mt} <= {2'h1, 16'h0020, 16'h0005, 16'h7000};
    weq(0, 16'h0020, 40);
    weq(0, 16'h0030, 40);
    repeat (40) @(negedge clk_in);
    weq(0, 16'h0030, 0);
    weq(2, 16'h0020, 0);
    @(posedge clk_in);
    mt <= 16'h0028;
    weq(0, 16'h0028, 40);
  endtask : t_vel
  task automatic t_pos();
    load(1, 16'h0100, 16'h0000, 16'h0000, 16'h0100);
    // Plain proportional inner loop, so torque follows the outer result
    load(0, 16'h0100, 16'h0000, 16'h0000, 16'h0000);
    @(posedge clk_in);
    {mode, pt, vt, sc, mt} <= {2'h2, 16'h0100, 16'h0, 16'h0040, 16'h7000};
    weq(2, 16'h0040, 80);
    weq(0, 16'h0040, 80);
    @(posedge clk_in);
    sc <= 16'h0200;
    weq(2, 16'h0100, 80);
    weq(0, 16'h0100, 80);
  endtask : t_pos
  task automatic t_imp();
    load(2, 16'h0200, 16'h0000, 16'h0080, 16'h0000);
    @(posedge clk_in);
    {mode, pt, vt, ff} <= {2'h3, 16'h0040, 16'h0100, 16'h0008};
    weq(0, 16'h0108, 1400);
    weq(3, 16'h0108, 2);
    @(posedge clk_in);
    mt <= 16'h0050;
    weq(0, 16'h0050, 1400);
    @(posedge clk_in);
    pm <= 16'h0100;
    weq(0, 16'hFFB0, 1400);
    @(posedge clk_in);
    {mt, pm} <= {16'h7000, 16'h0000};
    load(3, 16'h0030, 0, 0, 0);
    weq(0, 16'h0108, 1400);
    weq(3, 16'h0030, 4);
  endtask : t_imp
  task automatic t_nv();
    load(4, 0, 0, 0, 0);
    weq(6, 16'h0030, 0);
    chk("nv_write", {15'h0000, nw}, 16'h0001);
    // Save pulse must end before the next reset hides it
    @(negedge clk_in);
    chk("nv_write", {15'h0000, nw}, 16'h0000);
    @(negedge clk_in);
    boot(1, 16'h00C8);
    weq(4, 16'h0030, 0);
    // Gains written before reset must be gone
    weq(0, 16'h0058, 1400);
  endtask : t_nv
  task automatic t_pi();
    @(posedge clk_in);
    {pt, vt, ff, cm} <= {16'h0, 16'h0, 16'h0, 16'hF600};
    boot(0, 16'h0032);
    weq(1, 16'h05DC, 1400);
    weq(1, 16'h07D0, 1400);
  endtask : t_pi

  initial begin
    {rst_n, vl, pl, il, bl, cl, sv, ans, mode} = '0;
    {pt, vt, ff, kp, ki, kd, wu, mt, sc, clim, pm, vm, cm, bw} = '0;
    boot(1'b0, 16'h00C8);
    weq(4, DEF_CUR_LIMIT, 0);
    t_vel();
    t_pos();
    t_imp();
    t_nv();
    t_pi();
    close_out();
  end
endmodule : motor_loop_limits_tb_top
